// ==== rtl/rsf_consts.svh ====
// Offsets, field positions, reset values and limits of the service and flag registers.
// Assumes inclusion by the register block only.
`ifndef RSF_CONSTS_SVH
`define RSF_CONSTS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define RSF_IDX_CAL        8'h3b
`define RSF_IDX_TEMP       8'h3c
`define RSF_IDX_BAT        8'h3d
`define RSF_IDX_FLAGS1     8'h3e
`define RSF_IDX_FLAGS2     8'h3f

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RSF_CAL_AUTO_BIT     7
`define RSF_CAL_START_BIT    6
`define RSF_CAL_RUN_BIT      5
`define RSF_CAL_DRIFT_BIT    3
`define RSF_CAL_LIMIT_HI     2
`define RSF_CAL_LIMIT_LO     1
`define RSF_CAL_MONOFF_BIT   0
`define RSF_BAT_EN_BIT       3
`define RSF_BAT_SEL_HI       2
`define RSF_BAT_SEL_LO       0
`define RSF_F1_MODE_BIT      7
`define RSF_F1_RX_BIT        6
`define RSF_F1_TX_BIT        5
`define RSF_F1_LOCK_BIT      4
`define RSF_F1_RSSI_BIT      3
`define RSF_F1_TMO_BIT       2
`define RSF_F1_PRE_BIT       1
`define RSF_F1_SYNC_BIT      0
`define RSF_F2_FULL_BIT      7
`define RSF_F2_EMPTY_BIT     6
`define RSF_F2_LEVEL_BIT     5
`define RSF_F2_OVR_BIT       4
`define RSF_F2_SENT_BIT      3
`define RSF_F2_READY_BIT     2
`define RSF_F2_CHECK_BIT     1
`define RSF_F2_SUPPLY_BIT    0

// ----------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------
`define RSF_RST_LIMIT      2'h1
`define RSF_RST_BAT_SEL    3'h2
`define RSF_BUF_FULL_CNT   7'h42
`define RSF_DRIFT_5        8'h05
`define RSF_DRIFT_10       8'h0a
`define RSF_DRIFT_15       8'h0f
`define RSF_DRIFT_20       8'h14

`endif

// ==== rtl/rsf_pkg.sv ====
// Types shared by the service and flag register block.
// Assumes the radio core supplies its status as one packed struct.
package rsf_pkg;

  typedef enum logic [2:0] {
    RSF_SLEEP,
    RSF_STANDBY,
    RSF_FS,
    RSF_RX,
    RSF_TX
  } rsf_mode_t;

  typedef struct packed {
    rsf_mode_t   mode;
    logic        packet_mode;
    logic        mode_reached;
    logic        rx_settled;
    logic        tx_ramped;
    logic        pll_locked;
    logic        rssi_above;
    logic        timeout_hit;
    logic        preamble_seen;
    logic        sync_seen;
    logic        frame_done_tx;
    logic        payload_done;
    logic        check_pass;
    logic        overrun_hit;
    logic        supply_below;
    logic        cal_done;
    logic        temp_valid;
    logic [7:0]  temp_sample;
    logic [6:0]  buffer_count;
    logic [5:0]  buffer_level_limit;
  } rsf_radio_t;

  typedef struct packed {
    logic        cal_start;
    logic        auto_rx_cal_enable;
    logic        auto_cal_request;
    logic        thermal_monitor_active;
    logic        supply_detector_enable;
    logic [2:0]  supply_threshold_select;
    logic        buffer_flush;
  } rsf_ctrl_t;

endpackage : rsf_pkg

// ==== rtl/rsf_regs.sv ====
// Service and interrupt-flag registers, reached over APB.
// Assumes radio status inputs are synchronous to pclk; event inputs are one-cycle pulses.
`timescale 1ns/1ns
`default_nettype none
`include "rsf_consts.svh"

module rsf_regs (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output var  logic [31:0]        prdata,
  output var  logic               pready,
  output var  logic               pslverr,
  input  wire rsf_pkg::rsf_radio_t radio_i,
  output var  rsf_pkg::rsf_ctrl_t  ctrl_o
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] rsf_addr(input logic [7:0] idx);
    rsf_addr = {idx[5:0], 2'b00};
  endfunction : rsf_addr

  // Set wins over clear so an event in the clearing cycle survives
  function automatic logic rsf_flag(input logic cur, input logic set, input logic clr);
    rsf_flag = set | (cur & ~clr);
  endfunction : rsf_flag

  function automatic logic [7:0] rsf_limit(input logic [1:0] code);
    unique case (code)
      2'h0:    rsf_limit = `RSF_DRIFT_5;
      2'h1:    rsf_limit = `RSF_DRIFT_10;
      2'h2:    rsf_limit = `RSF_DRIFT_15;
      default: rsf_limit = `RSF_DRIFT_20;
    endcase
  endfunction : rsf_limit

  function automatic logic [7:0] rsf_absdiff(input logic [7:0] a, input logic [7:0] b);
    rsf_absdiff = (a > b) ? 8'(a - b) : 8'(b - a);
  endfunction : rsf_absdiff

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic               pready_ff;
  logic [31:0]        prdata_ff;
  logic               pslverr_ff;
  rsf_pkg::rsf_ctrl_t ctrl_ff;
  rsf_pkg::rsf_mode_t mode_prev_ff;
  logic               empty_prev_ff;

  logic        auto_en_ff;
  logic        cal_run_ff;
  logic        drift_ff;
  logic [1:0]  limit_ff;
  logic        mon_off_ff;
  logic [7:0]  temp_ff;
  logic [7:0]  former_ff;
  logic        bat_en_ff;
  logic [2:0]  bat_sel_ff;

  logic        mode_rdy_ff;
  logic        rx_rdy_ff;
  logic        tx_rdy_ff;
  logic        lock_ff;
  logic        rssi_ff;
  logic        tmo_ff;
  logic        pre_ff;
  logic        sync_ff;
  logic        full_ff;
  logic        empty_ff;
  logic        level_ff;
  logic        ovr_ff;
  logic        sent_ff;
  logic        ready_ff;
  logic        check_ff;
  logic        supply_ff;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  logic        wr;
  logic [7:0]  wb;
  logic        hit_cal;
  logic        hit_temp;
  logic        hit_bat;
  logic        hit_f1;
  logic        hit_f2;
  logic        hit;
  logic        wr_cal;
  logic        wr_bat;
  logic        wr_f1;
  logic        wr_f2;

  assign wr       = psel & penable & pwrite & pready_ff & pstrb[0];
  assign wb       = pwdata[7:0];
  assign hit_cal  = (paddr == rsf_addr(`RSF_IDX_CAL));
  assign hit_temp = (paddr == rsf_addr(`RSF_IDX_TEMP));
  assign hit_bat  = (paddr == rsf_addr(`RSF_IDX_BAT));
  assign hit_f1   = (paddr == rsf_addr(`RSF_IDX_FLAGS1));
  assign hit_f2   = (paddr == rsf_addr(`RSF_IDX_FLAGS2));
  assign hit      = hit_cal | hit_temp | hit_bat | hit_f1 | hit_f2;
  assign wr_cal   = wr & hit_cal;
  assign wr_bat   = wr & hit_bat;
  assign wr_f1    = wr & hit_f1;
  assign wr_f2    = wr & hit_f2;

  // ----------------------------------------------------------------------
  // Radio status decode
  // ----------------------------------------------------------------------
  logic       in_rx;
  logic       in_tx;
  logic       leave_rx;
  logic       leave_tx;
  logic       mode_chg;
  logic       buf_empty;
  logic       emptied;
  logic       mon_active;
  logic       drift_hit;
  logic       ovr_clr;

  assign in_rx      = (radio_i.mode == rsf_pkg::RSF_RX);
  assign in_tx      = (radio_i.mode == rsf_pkg::RSF_TX);
  assign mode_chg   = (radio_i.mode != mode_prev_ff);
  assign leave_rx   = (mode_prev_ff == rsf_pkg::RSF_RX) & ~in_rx;
  assign leave_tx   = (mode_prev_ff == rsf_pkg::RSF_TX) & ~in_tx;
  assign buf_empty  = (radio_i.buffer_count == 7'h00);
  assign emptied    = buf_empty & ~empty_prev_ff;
  // Monitoring is idle in Sleep and Standby to save current
  assign mon_active = ~mon_off_ff & (radio_i.mode != rsf_pkg::RSF_SLEEP)
                      & (radio_i.mode != rsf_pkg::RSF_STANDBY);
  assign drift_hit  = mon_active
                      & (rsf_absdiff(temp_ff, former_ff) > rsf_limit(limit_ff));
  assign ovr_clr    = wr_f2 & wb[`RSF_F2_OVR_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_prev_ff  <= rsf_pkg::RSF_SLEEP;
      empty_prev_ff <= 1'b1;
    end else begin
      mode_prev_ff  <= radio_i.mode;
      empty_prev_ff <= buf_empty;
    end
  end

  // ----------------------------------------------------------------------
  // Calibration and temperature
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_en_ff <= 1'b0;
      limit_ff   <= `RSF_RST_LIMIT;
      mon_off_ff <= 1'b0;
    end else if (wr_cal) begin
      auto_en_ff <= wb[`RSF_CAL_AUTO_BIT];
      limit_ff   <= wb[`RSF_CAL_LIMIT_HI:`RSF_CAL_LIMIT_LO];
      mon_off_ff <= wb[`RSF_CAL_MONOFF_BIT];
    end
  end

  logic cal_go;
  assign cal_go = wr_cal & wb[`RSF_CAL_START_BIT] & (radio_i.mode == rsf_pkg::RSF_STANDBY);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_run_ff <= 1'b0;
    end else begin
      cal_run_ff <= rsf_flag(cal_run_ff, cal_go, radio_i.cal_done);
    end
  end

  // A drift seen just as calibration ends is kept; former value then resets the distance
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_ff   <= 8'h00;
      former_ff <= 8'h00;
      drift_ff  <= 1'b0;
    end else begin
      if (radio_i.temp_valid && mon_active) begin
        temp_ff <= radio_i.temp_sample;
      end
      if (radio_i.cal_done) begin
        former_ff <= temp_ff;
      end
      drift_ff <= rsf_flag(drift_ff, drift_hit, radio_i.cal_done);
    end
  end

  // ----------------------------------------------------------------------
  // Battery monitor control
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bat_en_ff  <= 1'b0;
      bat_sel_ff <= `RSF_RST_BAT_SEL;
    end else if (wr_bat) begin
      bat_en_ff  <= wb[`RSF_BAT_EN_BIT];
      bat_sel_ff <= wb[`RSF_BAT_SEL_HI:`RSF_BAT_SEL_LO];
    end
  end

  // ----------------------------------------------------------------------
  // Radio state flags
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_rdy_ff <= 1'b0;
      rx_rdy_ff   <= 1'b0;
      tx_rdy_ff   <= 1'b0;
      lock_ff     <= 1'b0;
      rssi_ff     <= 1'b0;
      tmo_ff      <= 1'b0;
      pre_ff      <= 1'b0;
      sync_ff     <= 1'b0;
    end else begin
      mode_rdy_ff <= rsf_flag(mode_rdy_ff, radio_i.mode_reached, mode_chg);
      rx_rdy_ff   <= rsf_flag(rx_rdy_ff, radio_i.rx_settled & in_rx, ~in_rx);
      tx_rdy_ff   <= rsf_flag(tx_rdy_ff, radio_i.tx_ramped & in_tx, ~in_tx);
      lock_ff     <= radio_i.pll_locked & (radio_i.mode == rsf_pkg::RSF_FS | in_rx | in_tx);
      rssi_ff     <= rsf_flag(rssi_ff, radio_i.rssi_above & in_rx,
                              leave_rx | (wr_f1 & wb[`RSF_F1_RSSI_BIT]));
      tmo_ff      <= rsf_flag(tmo_ff, radio_i.timeout_hit, leave_rx | emptied);
      pre_ff      <= rsf_flag(pre_ff, radio_i.preamble_seen,
                              wr_f1 & wb[`RSF_F1_PRE_BIT]);
      sync_ff     <= rsf_flag(sync_ff, radio_i.sync_seen,
                              leave_rx | emptied
                              | (wr_f1 & wb[`RSF_F1_SYNC_BIT] & ~radio_i.packet_mode));
    end
  end

  // ----------------------------------------------------------------------
  // Buffer and packet flags
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_ff   <= 1'b0;
      empty_ff  <= 1'b1;
      level_ff  <= 1'b0;
      ovr_ff    <= 1'b0;
      sent_ff   <= 1'b0;
      ready_ff  <= 1'b0;
      check_ff  <= 1'b0;
      supply_ff <= 1'b0;
    end else begin
      full_ff   <= (radio_i.buffer_count == `RSF_BUF_FULL_CNT);
      empty_ff  <= buf_empty;
      level_ff  <= (radio_i.buffer_count > {1'b0, radio_i.buffer_level_limit});
      ovr_ff    <= rsf_flag(ovr_ff, radio_i.overrun_hit & (radio_i.mode != rsf_pkg::RSF_SLEEP),
                            ovr_clr);
      sent_ff   <= rsf_flag(sent_ff, radio_i.frame_done_tx & in_tx, leave_tx);
      ready_ff  <= rsf_flag(ready_ff, radio_i.payload_done & in_rx, emptied);
      check_ff  <= rsf_flag(check_ff, radio_i.check_pass & in_rx, emptied);
      supply_ff <= rsf_flag(supply_ff, radio_i.supply_below & bat_en_ff,
                            wr_f2 & wb[`RSF_F2_SUPPLY_BIT]);
    end
  end

  // ----------------------------------------------------------------------
  // Control outputs to the radio core
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= '0;
      ctrl_ff.supply_threshold_select <= `RSF_RST_BAT_SEL;
    end else begin
      ctrl_ff.cal_start               <= cal_go;
      ctrl_ff.auto_rx_cal_enable      <= auto_en_ff;
      ctrl_ff.auto_cal_request        <= auto_en_ff & drift_hit & ~drift_ff;
      ctrl_ff.thermal_monitor_active  <= mon_active;
      ctrl_ff.supply_detector_enable  <= bat_en_ff;
      ctrl_ff.supply_threshold_select <= bat_sel_ff;
      ctrl_ff.buffer_flush            <= ovr_clr;
    end
  end

  // ----------------------------------------------------------------------
  // Read path: one wait state keeps every bus output on a flop
  // ----------------------------------------------------------------------
  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = 8'h00;
    if (hit_cal) begin
      rd_byte[`RSF_CAL_AUTO_BIT]                   = auto_en_ff;
      rd_byte[`RSF_CAL_RUN_BIT]                    = cal_run_ff;
      rd_byte[`RSF_CAL_DRIFT_BIT]                  = drift_ff;
      rd_byte[`RSF_CAL_LIMIT_HI:`RSF_CAL_LIMIT_LO] = limit_ff;
      rd_byte[`RSF_CAL_MONOFF_BIT]                 = mon_off_ff;
    end else if (hit_temp) begin
      rd_byte = temp_ff;
    end else if (hit_bat) begin
      rd_byte[`RSF_BAT_EN_BIT]                 = bat_en_ff;
      rd_byte[`RSF_BAT_SEL_HI:`RSF_BAT_SEL_LO] = bat_sel_ff;
    end else if (hit_f1) begin
      rd_byte = {mode_rdy_ff, rx_rdy_ff, tx_rdy_ff, lock_ff,
                 rssi_ff, tmo_ff, pre_ff, sync_ff};
    end else if (hit_f2) begin
      rd_byte = {full_ff, empty_ff, level_ff, ovr_ff,
                 sent_ff, ready_ff, check_ff, supply_ff};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (psel && penable && !pready_ff) begin
      pready_ff  <= 1'b1;
      prdata_ff  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      pslverr_ff <= ~hit;
    end else begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign ctrl_o  = ctrl_ff;

endmodule : rsf_regs

`default_nettype wire

// ==== test/rsf_regs_properties.sv ====
// Concurrent checks on the ports of the service and flag register block.
// Assumes it is bound onto rsf_regs and that the APB master holds requests until pready.
`timescale 1ns/1ns
`default_nettype none
module rsf_regs_properties (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [7:0]           paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [3:0]           pstrb,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire rsf_pkg::rsf_radio_t  radio_i,
  input wire rsf_pkg::rsf_ctrl_t   ctrl_o
);
  // ----------------------------------------------------------------------
  // Helper terms
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic acc_w;
  logic cal_wr;
  logic mode_sb;
  logic mon_idle;
  assign acc_w    = psel && penable && pready && pwrite && pstrb[0];
  assign cal_wr   = acc_w && (paddr == 8'hec) && pwdata[6];
  assign mode_sb  = (radio_i.mode == rsf_pkg::RSF_STANDBY);
  assign mon_idle = mode_sb || (radio_i.mode == rsf_pkg::RSF_SLEEP);
  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing after first access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_err_decode: assert property (pready |-> pslverr == !(paddr inside
    {8'hec, 8'hf0, 8'hf4, 8'hf8, 8'hfc}))
    else $error("pslverr does not match address decode");
  a_idle_rdata: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("prdata nonzero outside ready cycle");
  a_cal_start: assert property (cal_wr |=> ctrl_o.cal_start == $past(mode_sb))
    else $error("calibration start pulse wrong");
  a_cal_cause: assert property (ctrl_o.cal_start |-> $past(cal_wr) && $past(mode_sb))
    else $error("calibration start without valid trigger");
  a_auto_en: assert property (acc_w && paddr == 8'hec |=> ##1
    ctrl_o.auto_rx_cal_enable == $past(pwdata[7], 2))
    else $error("auto calibration enable not written");
  a_bat_ctrl: assert property (acc_w && paddr == 8'hf4 |=> ##1
    {ctrl_o.supply_detector_enable, ctrl_o.supply_threshold_select} == $past(pwdata[3:0], 2))
    else $error("supply detector controls not written");
  a_flush_pulse: assert property (acc_w && paddr == 8'hfc && pwdata[4] |=>
    ctrl_o.buffer_flush ##1 !ctrl_o.buffer_flush)
    else $error("buffer flush pulse wrong");
  a_mon_off: assert property ($past(mon_idle) |-> !ctrl_o.thermal_monitor_active)
    else $error("monitor active in sleep or standby");
  a_auto_req: assert property (ctrl_o.auto_cal_request |->
    ctrl_o.auto_rx_cal_enable ##1 !ctrl_o.auto_cal_request)
    else $error("auto calibration request not a single enabled pulse");
  c_auto: cover property (ctrl_o.auto_cal_request);
  c_cal: cover property (ctrl_o.cal_start);
  c_flush: cover property (ctrl_o.buffer_flush);
  c_err: cover property (pready && pslverr);
endmodule : rsf_regs_properties

bind rsf_regs rsf_regs_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .radio_i, .ctrl_o);
`default_nettype wire

// ==== test/radio_service_and_irq_flags_test.sv ====
// Self-checking bench for the service and flag register block.
// Assumes rsf_pkg, rsf_regs and the bound checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module radio_service_and_irq_flags_test;
  logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0]          paddr;
  logic [31:0]         pwdata, prdata, rdv;
  logic [3:0]          pstrb;
  logic [15:0]         lf;
  rsf_pkg::rsf_radio_t radio;
  rsf_pkg::rsf_ctrl_t  ctrl;
  int                  errors, compares, cyc, cnt, lim;
  int                  lims[4] = '{5, 10, 15, 20};

  rsf_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .radio_i(radio), .ctrl_o(ctrl));

  // ----------------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic print_verdict;
    if (errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // Generous ceiling; the sequence needs well under a thousand cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      print_verdict();
    end
  end

  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_step

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  // Holds the whole request until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n == 16) errors++;
    rdv = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(rdv, {24'h00_0000, e});
  endtask : rd

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
    radio = '0;
    radio.mode = rsf_pkg::RSF_STANDBY;
    {errors, compares, cyc} = '0;
    lf = 16'hb96d;
    tick(4);
    presetn <= 1'b1;
    rd(8'hec, 8'h02);
    rd(8'hf4, 8'h02);
    rd(8'hf8, 8'h00);
    rd(8'hfc, 8'h40);
    apb(1'b0, 8'he8, 8'h00);
    chk({31'h0000_0000, perr}, 32'h0000_0001);
    apb(1'b1, 8'h00, 8'hff);
    chk({31'h0000_0000, perr}, 32'h0000_0001);
    // Start trigger in every mode; only standby may run it
    for (int m = 0; m < 5; m++) begin
      radio.mode <= rsf_pkg::rsf_mode_t'(m);
      apb(1'b1, 8'hec, 8'hdd);
      rd(8'hec, (m == 1) ? 8'ha5 : 8'h85);
      radio.cal_done <= 1'b1;
      tick(1);
      radio.cal_done <= 1'b0;
      rd(8'hec, 8'h85);
    end
    radio.mode <= rsf_pkg::RSF_RX;
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, 8'hec, 8'(c << 1));
      radio.temp_sample <= 8'h00;
      radio.temp_valid <= 1'b1;
      tick(1);
      radio.cal_done <= 1'b1;
      tick(1);
      radio.cal_done <= 1'b0;
      radio.temp_sample <= 8'(lims[c]);
      radio.temp_valid <= 1'b1;
      tick(1);
      radio.temp_valid <= 1'b0;
      rd(8'hf0, 8'(lims[c]));
      rd(8'hec, 8'(c << 1));
      radio.temp_sample <= 8'(lims[c] + 1);
      radio.temp_valid <= 1'b1;
      tick(1);
      radio.temp_valid <= 1'b0;
      rd(8'hec, 8'(c << 1) | 8'h08);
    end
    // Monitor switched off, drift cleared by calibration: no new reading, no drift
    apb(1'b1, 8'hec, 8'h01);
    radio.cal_done <= 1'b1;
    radio.temp_sample <= 8'h40;
    radio.temp_valid <= 1'b1;
    tick(1);
    {radio.cal_done, radio.temp_valid} <= 2'b00;
    rd(8'hec, 8'h01);
    rd(8'hf0, 8'(lims[3] + 1));
    // Auto calibration on: a fresh drift raises one request
    apb(1'b1, 8'hec, 8'h80);
    radio.temp_sample <= 8'h40;
    radio.temp_valid <= 1'b1;
    tick(1);
    radio.temp_valid <= 1'b0;
    tick(2);
    chk({31'h0000_0000, ctrl.auto_cal_request}, 32'h0000_0001);
    rd(8'hec, 8'h88);
    for (int i = 0; i < 4; i++) begin
      lf = lfsr_step(lf);
      apb(1'b1, 8'hf4, lf[7:0]);
      rd(8'hf4, {4'h0, lf[3:0]});
    end
    apb(1'b1, 8'hf4, 8'h0b);
    radio.supply_below <= 1'b1;
    tick(1);
    radio.supply_below <= 1'b0;
    rd(8'hfc, 8'h41);
    apb(1'b1, 8'hfc, 8'h00);
    rd(8'hfc, 8'h41);
    apb(1'b1, 8'hfc, 8'h01);
    rd(8'hfc, 8'h40);
    {radio.rssi_above, radio.timeout_hit, radio.preamble_seen, radio.sync_seen} <= 4'hf;
    tick(1);
    {radio.rssi_above, radio.timeout_hit, radio.preamble_seen, radio.sync_seen} <= 4'h0;
    rd(8'hf8, 8'h0f);
    apb(1'b1, 8'hf8, 8'h00);
    rd(8'hf8, 8'h0f);
    apb(1'b1, 8'hf8, 8'h02);
    rd(8'hf8, 8'h0d);
    apb(1'b1, 8'hf8, 8'h09);
    rd(8'hf8, 8'h04);
    radio.mode <= rsf_pkg::RSF_FS;
    rd(8'hf8, 8'h00);
    // Packet mode: sync flag ignores the clear write, falls when emptied
    radio.mode <= rsf_pkg::RSF_RX;
    {radio.packet_mode, radio.sync_seen, radio.buffer_count} <= {2'b11, 7'h03};
    tick(1);
    radio.sync_seen <= 1'b0;
    apb(1'b1, 8'hf8, 8'h01);
    rd(8'hf8, 8'h01);
    radio.buffer_count <= 7'h00;
    rd(8'hf8, 8'h00);
    radio.mode <= rsf_pkg::RSF_FS;
    {radio.pll_locked, radio.mode_reached} <= 2'b11;
    tick(1);
    radio.mode_reached <= 1'b0;
    rd(8'hf8, 8'h90);
    radio.mode <= rsf_pkg::RSF_RX;
    radio.rx_settled <= 1'b1;
    tick(1);
    radio.rx_settled <= 1'b0;
    rd(8'hf8, 8'h50);
    radio.mode <= rsf_pkg::RSF_TX;
    radio.tx_ramped <= 1'b1;
    tick(1);
    radio.tx_ramped <= 1'b0;
    rd(8'hf8, 8'h30);
    {radio.pll_locked, radio.mode} <= {1'b0, rsf_pkg::RSF_RX};
    {radio.buffer_count, radio.buffer_level_limit} <= {7'h05, 6'h3f};
    {radio.payload_done, radio.check_pass} <= 2'b11;
    tick(1);
    {radio.payload_done, radio.check_pass} <= 2'b00;
    rd(8'hf8, 8'h00);
    rd(8'hfc, 8'h06);
    radio.buffer_count <= 7'h00;
    rd(8'hfc, 8'h40);
    {radio.mode, radio.frame_done_tx} <= {rsf_pkg::RSF_TX, 1'b1};
    tick(1);
    radio.frame_done_tx <= 1'b0;
    rd(8'hfc, 8'h48);
    {radio.mode, radio.overrun_hit} <= {rsf_pkg::RSF_SLEEP, 1'b1};
    tick(1);
    radio.overrun_hit <= 1'b0;
    rd(8'hfc, 8'h40);
    {radio.mode, radio.overrun_hit} <= {rsf_pkg::RSF_RX, 1'b1};
    tick(1);
    radio.overrun_hit <= 1'b0;
    rd(8'hfc, 8'h50);
    apb(1'b1, 8'hfc, 8'h10);
    rd(8'hfc, 8'h40);
    for (int i = 0; i < 8; i++) begin
      lf = lfsr_step(lf);
      lim = int'(lf[13:8]);
      cnt = (i == 0) ? 66 : (i == 1) ? 0 : (i == 2) ? lim : int'(lf[15:0]) % 67;
      radio.buffer_count <= 7'(cnt);
      radio.buffer_level_limit <= 6'(lim);
      rd(8'hfc, {cnt == 66, cnt == 0, cnt > lim, 5'h00});
    end
    // Mid-run reset, then a write with byte lane 0 off must be ignored
    presetn <= 1'b0;
    tick(2);
    presetn <= 1'b1;
    rd(8'hec, 8'h02);
    rd(8'hf4, 8'h02);
    pstrb <= 4'he;
    apb(1'b1, 8'hf4, 8'h0f);
    pstrb <= 4'hf;
    rd(8'hf4, 8'h02);
    print_verdict();
  end
endmodule : radio_service_and_irq_flags_test
`default_nettype wire
